// ### shared/tfcr_pkg.sv
// shared constants, types and rom packing for the tracking filter cal block
package tfcr_pkg;

	// register byte offsets on the wishbone slave
	localparam logic [7:0] TFCR_OFS_SERIES   = 8'h00;
	localparam logic [7:0] TFCR_OFS_PARALLEL = 8'h04;
	localparam logic [7:0] TFCR_OFS_ROM_IDX  = 8'h08;
	localparam logic [7:0] TFCR_OFS_READBACK = 8'h0C;
	localparam logic [7:0] TFCR_OFS_OVERLOAD = 8'h10;

	// field widths and reset values
	localparam int          TFCR_SERIES_W   = 8;
	localparam int          TFCR_PARALLEL_W = 6;
	localparam int          TFCR_IDX_W      = 4;
	localparam int          TFCR_OVL_W      = 3;
	localparam logic [7:0]  TFCR_SERIES_RST   = 8'h00;
	localparam logic [5:0]  TFCR_PARALLEL_RST = 6'h00;
	localparam logic [3:0]  TFCR_IDX_RST      = 4'h0;
	localparam logic [2:0]  TFCR_OVL_RST      = 3'h0;
	localparam logic [7:0]  TFCR_ROM_RST      = 8'h00;

	// calibration rom addresses
	localparam logic [3:0] TFCR_ROM_OVL   = 4'h0;
	localparam logic [3:0] TFCR_ROM_VLO_A = 4'h1;
	localparam logic [3:0] TFCR_ROM_VLO_B = 4'h2;
	localparam logic [3:0] TFCR_ROM_MIX_C = 4'h3;
	localparam logic [3:0] TFCR_ROM_VHI_A = 4'h4;
	localparam logic [3:0] TFCR_ROM_VHI_B = 4'h5;
	localparam logic [3:0] TFCR_ROM_UHF_A = 4'h6;
	localparam logic [3:0] TFCR_ROM_UHF_B = 4'h7;
	localparam logic [3:0] TFCR_ROM_UHF_C = 4'h8;

	// wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} tfcr_wb_req_t;

	// wishbone answer from the slave
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} tfcr_wb_rsp_t;

	// factory calibration coefficients
	typedef struct packed {
		logic [2:0] overload_cal_value;
		logic [5:0] vlow_series_intercept;
		logic [3:0] vlow_series_slope;
		logic [5:0] vlow_parallel_intercept;
		logic [3:0] vlow_parallel_slope;
		logic [5:0] vhigh_series_intercept;
		logic [3:0] vhigh_series_slope;
		logic [5:0] vhigh_parallel_intercept;
		logic [3:0] vhigh_parallel_slope;
		logic [5:0] uhf_series_intercept;
		logic [5:0] uhf_series_slope;
		logic [5:0] uhf_parallel_intercept;
		logic [5:0] uhf_parallel_slope;
	} tfcr_coef_t;

	// plain stand-in calibration contents
	localparam tfcr_coef_t TFCR_COEF_DEFAULT =
		tfcr_coef_t'(67'h5_A5C3_3C96_1E87_B4D2);

	// packs the coefficients into the byte stored at one rom address
	function automatic logic [7:0] tfcr_rom_byte(input tfcr_coef_t c,
		input logic [3:0] idx);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			TFCR_ROM_OVL:   b = {c.overload_cal_value, 5'h00};
			TFCR_ROM_VLO_A: b = {c.vlow_series_intercept,
				c.vlow_series_slope[3:2]};
			TFCR_ROM_VLO_B: b = {c.vlow_series_slope[1:0],
				c.vlow_parallel_intercept};
			TFCR_ROM_MIX_C: b = {c.vlow_parallel_slope,
				c.vhigh_series_intercept[5:2]};
			TFCR_ROM_VHI_A: b = {c.vhigh_series_intercept[1:0],
				c.vhigh_series_slope, c.vhigh_parallel_intercept[5:4]};
			TFCR_ROM_VHI_B: b = {c.vhigh_parallel_intercept[3:0],
				c.vhigh_parallel_slope};
			TFCR_ROM_UHF_A: b = {c.uhf_series_intercept,
				c.uhf_series_slope[5:4]};
			TFCR_ROM_UHF_B: b = {c.uhf_series_slope[3:0],
				c.uhf_parallel_intercept[5:2]};
			TFCR_ROM_UHF_C: b = {c.uhf_parallel_intercept[1:0],
				c.uhf_parallel_slope};
			default:        b = 8'h00;
		endcase
		return b;
	endfunction : tfcr_rom_byte

endpackage : tfcr_pkg

// ### design/tfcr_cal_rom.sv
// calibration rom with registered read data
`timescale 1ns/1ps
module tfcr_cal_rom
	import tfcr_pkg::*;
#(
	parameter tfcr_coef_t COEF = TFCR_COEF_DEFAULT
) (
	input  wire logic       clk_i,   // system clock
	input  wire logic       rst_i,   // sync reset, high
	input  wire logic [3:0] idx_i,   // rom address
	output logic      [7:0] data_o   // byte at idx_i, one cycle later
);
	logic [7:0] data_d;
	logic [7:0] data_q;

	always_comb begin
		data_d = tfcr_rom_byte(COEF, idx_i);
	end

	// read register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_q <= TFCR_ROM_RST;
		end else begin
			data_q <= data_d;
		end
	end

	assign data_o = data_q;

endmodule : tfcr_cal_rom

// ### design/tfcr_top.sv
// tracking filter capacitor codes and calibration rom readout, wishbone slave
//
// Overview of operation
// - series code 8 bits and parallel code 6 bits, each in own register
// - device copies byte at written rom address into the readback field
// - rom address 0 holds overload calibration in D7..D5, rest meaningless
// - vhf-low intercepts and slopes packed msb first over addresses 1 to 3
// - vhf-high intercepts and slopes packed over addresses 3 to 5
// - uhf six-bit coefficients packed over addresses 6 to 8
`timescale 1ns/1ps
module tfcr_top
	import tfcr_pkg::*;
#(
	parameter tfcr_coef_t CAL_COEF = TFCR_COEF_DEFAULT
) (
	input  wire logic                   clk_i,        // 100 mhz clock
	input  wire logic                   rst_i,        // sync reset, high
	input  wire tfcr_pkg::tfcr_wb_req_t wb_req_i,     // wishbone request
	output tfcr_pkg::tfcr_wb_rsp_t      wb_rsp_o,     // wishbone answer
	output logic [7:0]                  series_cap_code_o,   // series array
	output logic [5:0]                  parallel_cap_code_o, // parallel array
	output logic [2:0]                  overload_cal_value_o // overload trim
);
	import tfcr_pkg::*;

	logic         req_take;
	logic         wr_en;
	logic         wr_series;
	logic         wr_parallel;
	logic         wr_idx;
	logic         wr_ovl;
	logic [7:0]   rom_q;

	logic [7:0]   series_d;
	logic [7:0]   series_q;
	logic [5:0]   parallel_d;
	logic [5:0]   parallel_q;
	logic [3:0]   idx_d;
	logic [3:0]   idx_q;
	logic [2:0]   ovl_d;
	logic [2:0]   ovl_q;

	logic         ack_d;
	logic         ack_q;
	logic [31:0]  rdat_d;
	logic [31:0]  rdat_q;

	// request taken once, ack not yet given
	assign req_take = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
	// only byte lane 0 carries fields
	assign wr_en = req_take & wb_req_i.we & wb_req_i.sel[0];
	assign wr_series   = wr_en & (wb_req_i.adr == TFCR_OFS_SERIES);
	assign wr_parallel = wr_en & (wb_req_i.adr == TFCR_OFS_PARALLEL);
	assign wr_idx      = wr_en & (wb_req_i.adr == TFCR_OFS_ROM_IDX);
	assign wr_ovl      = wr_en & (wb_req_i.adr == TFCR_OFS_OVERLOAD);

	// next values of the control registers
	always_comb begin
		series_d   = series_q;
		parallel_d = parallel_q;
		idx_d      = idx_q;
		ovl_d      = ovl_q;
		if (wr_series) begin
			series_d = wb_req_i.dat[7:0];
		end
		if (wr_parallel) begin
			parallel_d = wb_req_i.dat[5:0];
		end
		if (wr_idx) begin
			idx_d = wb_req_i.dat[3:0];
		end
		if (wr_ovl) begin
			ovl_d = wb_req_i.dat[2:0];
		end
	end

	// control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			series_q   <= TFCR_SERIES_RST;
			parallel_q <= TFCR_PARALLEL_RST;
			idx_q      <= TFCR_IDX_RST;
			ovl_q      <= TFCR_OVL_RST;
		end else begin
			series_q   <= series_d;
			parallel_q <= parallel_d;
			idx_q      <= idx_d;
			ovl_q      <= ovl_d;
		end
	end

	// rom byte follows the index register
	tfcr_cal_rom #(
		.COEF   (CAL_COEF)
	) u_rom (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.idx_i  (idx_q),
		.data_o (rom_q)
	);

	// bus answer: ack one cycle after the request, read mux
	always_comb begin
		ack_d  = req_take;
		rdat_d = 32'h0000_0000;
		if (req_take & ~wb_req_i.we) begin
			case (wb_req_i.adr)
				TFCR_OFS_SERIES:   rdat_d = {24'h00_0000, series_q};
				TFCR_OFS_PARALLEL: rdat_d = {26'h000_0000, parallel_q};
				TFCR_OFS_ROM_IDX:  rdat_d = {28'h000_0000, idx_q};
				TFCR_OFS_READBACK: rdat_d = {24'h00_0000, rom_q};
				TFCR_OFS_OVERLOAD: rdat_d = {29'h0000_0000, ovl_q};
				default:           rdat_d = 32'h0000_0000;
			endcase
		end
	end

	// bus answer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_rsp_o.ack          = ack_q;
	assign wb_rsp_o.dat          = rdat_q;
	assign series_cap_code_o     = series_q;
	assign parallel_cap_code_o   = parallel_q;
	assign overload_cal_value_o  = ovl_q;

	// checks on the documented behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_req_i.cyc & wb_req_i.stb & ~ack_q;
	endsequence

	sequence s_idx_write;
		wr_idx;
	endsequence

	bus_ack_a: assert property (s_req |=> ack_q ##1 !ack_q)
		else $error("ack not a single pulse after request");

	series_write_a: assert property (wr_series |=>
		series_cap_code_o == $past(wb_req_i.dat[7:0]))
		else $error("series code not loaded");

	parallel_write_a: assert property (wr_parallel |=>
		parallel_cap_code_o == $past(wb_req_i.dat[5:0]))
		else $error("parallel code not loaded");

	rom_readback_a: assert property (s_idx_write ##2 1'b1 |->
		rom_q == tfcr_rom_byte(CAL_COEF, $past(wb_req_i.dat[3:0], 2)))
		else $error("readback does not follow rom address");

	// read register already holds the address-zero byte one edge after release
	overload_byte_a: assert property (!rst_i && idx_q == TFCR_ROM_OVL
		|=> rom_q == {CAL_COEF.overload_cal_value, 5'h00})
		else $error("overload calibration byte wrong");

	vlow_pack_a: assert property (idx_q == TFCR_ROM_VLO_B |=>
		rom_q == {CAL_COEF.vlow_series_slope[1:0],
		CAL_COEF.vlow_parallel_intercept})
		else $error("vhf-low packing wrong");

	vhigh_pack_a: assert property (idx_q == TFCR_ROM_VHI_A |=>
		rom_q == {CAL_COEF.vhigh_series_intercept[1:0],
		CAL_COEF.vhigh_series_slope,
		CAL_COEF.vhigh_parallel_intercept[5:4]})
		else $error("vhf-high packing wrong");

	uhf_pack_a: assert property (idx_q == TFCR_ROM_UHF_B |=>
		rom_q == {CAL_COEF.uhf_series_slope[3:0],
		CAL_COEF.uhf_parallel_intercept[5:2]})
		else $error("uhf packing wrong");

	vlow_head_a: assert property (idx_q == TFCR_ROM_VLO_A |=>
		rom_q == {CAL_COEF.vlow_series_intercept,
		CAL_COEF.vlow_series_slope[3:2]})
		else $error("vhf-low first byte wrong");

	band_seam_a: assert property (idx_q == TFCR_ROM_MIX_C |=>
		rom_q == {CAL_COEF.vlow_parallel_slope,
		CAL_COEF.vhigh_series_intercept[5:2]})
		else $error("vhf-low to vhf-high seam byte wrong");

	vhigh_tail_a: assert property (idx_q == TFCR_ROM_VHI_B |=>
		rom_q == {CAL_COEF.vhigh_parallel_intercept[3:0],
		CAL_COEF.vhigh_parallel_slope})
		else $error("vhf-high last byte wrong");

	uhf_head_a: assert property (idx_q == TFCR_ROM_UHF_A |=>
		rom_q == {CAL_COEF.uhf_series_intercept,
		CAL_COEF.uhf_series_slope[5:4]})
		else $error("uhf first byte wrong");

	uhf_tail_a: assert property (idx_q == TFCR_ROM_UHF_C |=>
		rom_q == {CAL_COEF.uhf_parallel_intercept[1:0],
		CAL_COEF.uhf_parallel_slope})
		else $error("uhf last byte wrong");

	// addresses past the table read as zero
	blank_rom_a: assert property (idx_q > TFCR_ROM_UHF_C |=>
		rom_q == 8'h00)
		else $error("unused rom address not zero");

	index_write_a: assert property (s_idx_write |=>
		idx_q == $past(wb_req_i.dat[3:0]))
		else $error("rom index not loaded");

endmodule : tfcr_top

// ### testbench/tfcr_host_model.sv
// host side wishbone master model
`timescale 1ns/1ps
module tfcr_host_model
	import tfcr_pkg::*;
(
	input  wire logic               clk_i,    // system clock
	input  wire tfcr_pkg::tfcr_wb_rsp_t wb_rsp_i, // slave answer
	output tfcr_pkg::tfcr_wb_req_t  wb_req_o  // master request
);
	// bus idle from time zero
	initial wb_req_o = '0;

	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_req_o <= '{1'b1, 1'b1, we, a, s, d};
		// hold everything until ack is seen
		do @(posedge clk_i); while (wb_rsp_i.ack !== 1'b1);
		q = wb_rsp_i.dat;
		wb_req_o <= '0;
	endtask : xfer

	// host formulas per band, f in megahertz
	function automatic int cap_code(input int band, input bit par,
		input int f, input logic [63:0] cb);
		real b;
		real m;
		real e;
		int  k;
		int  off;
		off = 0;
		if (band == 0 && !par) begin
			b = cb[63:58];
			m = cb[57:54];
			e = (1.1 * b / 64 + 2.2) + (4 * m / 16 - 12) * f * 0.001;
			off = 10;
		end else if (band == 0) begin
			b = cb[53:48];
			m = cb[47:44];
			e = (0.8 * b / 64 + 1.6) + (8 * m / 16 - 14) * f * 0.001;
		end else if (band == 1 && !par) begin
			b = cb[43:38];
			m = cb[37:34];
			e = (1.3 * b / 64 + 2.5) + (4 * m / 16 - 8) * f * 0.001;
			off = 10;
		end else if (band == 1) begin
			b = cb[33:28];
			m = cb[27:24];
			e = (0.8 * b / 64 + 1.6) + (1.6 * m / 16 - 3.2) * f * 0.001;
		end else if (!par) begin
			b = cb[23:18];
			m = cb[17:12];
			e = (b / 64 + 3) + (2 * m / 64 - 3) * f * 0.001;
		end else begin
			b = cb[11:6];
			m = cb[5:0];
			e = (0.8 * b / 64 + 1.6) + (2 * m / 64 - 2.5) * f * 0.001;
		end
		// truncate toward zero, then clamp to the field
		k = $rtoi(10.0 ** e) - off;
		if (k < 0)
			k = 0;
		if (k > (par ? 63 : 255))
			k = par ? 63 : 255;
		return k;
	endfunction : cap_code
endmodule : tfcr_host_model

// ### testbench/tfcr_top_tb.sv
// self-checking bench for the cal rom readout block
`timescale 1ns/1ps
module tfcr_top_tb;
	import tfcr_pkg::*;
	localparam logic [66:0] CW = 67'h3_9E1C_72D5_48B6_0FA3; // test rom
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	tfcr_wb_req_t wb_req;
	tfcr_wb_rsp_t wb_rsp;
	logic [7:0]   series;
	logic [5:0]   parallel;
	logic [2:0]   ovl;
	logic [31:0]  exp_q[$];
	logic [31:0]  v;
	logic [31:0]  mem[16];
	int           err_count = 0;
	int           total_checks = 0;
	int           cycles = 0;
	logic [63:0]  cb;
	int           f;
	int           bd;
	int           sc;
	int           pc;

	initial forever #5 clk_i = ~clk_i;

	tfcr_top #(.CAL_COEF(tfcr_coef_t'(CW))) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
		.series_cap_code_o(series), .parallel_cap_code_o(parallel),
		.overload_cal_value_o(ovl));
	tfcr_host_model host (.clk_i(clk_i), .wb_rsp_i(wb_rsp),
		.wb_req_o(wb_req));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize();
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// bus access that notes its expected read data
	task automatic acc(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d, input logic [31:0] e,
		output logic [31:0] q);
		exp_q.push_back(we ? 32'h0 : e);
		host.xfer(we, a, s, d, q);
	endtask : acc

	// byte expected at one rom address, msb first packing
	function automatic logic [31:0] rom_exp(input int k);
		if (k == 0)
			return {24'h0, CW[66:64], 5'h00};
		if (k > 8)
			return 32'h0;
		return {24'h0, CW[71 - 8 * k -: 8]};
	endfunction : rom_exp

	// each answer takes the oldest note; no note gives a mismatch
	always @(posedge clk_i) begin
		if (wb_rsp.ack === 1'b1)
			check(wb_rsp.dat, exp_q.size() ? exp_q.pop_front() : '1);
	end

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		void'($urandom(32'h6a59));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, unmapped place reads zero
		acc(0, TFCR_OFS_SERIES, 4'hF, 0, 0, v);
		acc(0, TFCR_OFS_PARALLEL, 4'hF, 0, 0, v);
		acc(0, TFCR_OFS_ROM_IDX, 4'hF, 0, 0, v);
		acc(0, TFCR_OFS_READBACK, 4'hF, 0, rom_exp(0), v);
		acc(0, TFCR_OFS_OVERLOAD, 4'hF, 0, 0, v);
		acc(0, 8'h14, 4'hF, 0, 0, v);
		// index first, then readback, kept locally
		for (int k = 0; k < 16; k++) begin
			acc(1, TFCR_OFS_ROM_IDX, 4'h1, k, 0, v);
			acc(0, TFCR_OFS_READBACK, 4'hF, 0, rom_exp(k), mem[k]);
		end
		// overload trim copied from rom address zero
		acc(1, TFCR_OFS_OVERLOAD, 4'h1, mem[0][7:5], 0, v);
		check({29'h0, ovl}, {29'h0, CW[66:64]});
		// codes rewritten per channel
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			acc(1, TFCR_OFS_SERIES, 4'hF, v, 0, mem[15]);
			acc(1, TFCR_OFS_PARALLEL, 4'h1, ~v, 0, mem[15]);
			check({24'h0, series}, {24'h0, v[7:0]});
			check({26'h0, parallel}, {26'h0, ~v[5:0]});
			acc(0, TFCR_OFS_PARALLEL, 4'hF, 0, {26'h0, ~v[5:0]}, mem[15]);
		end
		// lane zero disabled and read-only readback leave state alone
		acc(1, TFCR_OFS_SERIES, 4'hE, ~v, 0, mem[15]);
		check({24'h0, series}, {24'h0, v[7:0]});
		acc(1, TFCR_OFS_READBACK, 4'hF, 32'hFF, 0, mem[15]);
		acc(0, TFCR_OFS_READBACK, 4'hF, 0, rom_exp(15), mem[15]);
		// coefficients rebuilt from the local copy of the rom
		cb = {mem[1][7:0], mem[2][7:0], mem[3][7:0], mem[4][7:0],
			mem[5][7:0], mem[6][7:0], mem[7][7:0], mem[8][7:0]};
		// both codes recomputed and rewritten on each channel
		for (int i = 0; i < 6; i++) begin
			bd = i % 3;
			// channel frequency in megahertz, inside its band
			if (bd == 0)
				f = 47 + $urandom % 53;
			else if (bd == 1)
				f = 100 + $urandom % 226;
			else
				f = 326 + $urandom % 537;
			sc = host.cap_code(bd, 1'b0, f, cb);
			pc = host.cap_code(bd, 1'b1, f, cb);
			acc(1, TFCR_OFS_SERIES, 4'h1, sc, 0, v);
			acc(1, TFCR_OFS_PARALLEL, 4'h1, pc, 0, v);
			check({24'h0, series}, sc);
			check({26'h0, parallel}, pc);
		end
		@(posedge clk_i);
		summarize();
	end
endmodule : tfcr_top_tb
